/* File: cef_defines.svh */
// Purpose: constants for the error flag and interrupt core
// Assumes: byte-wide register port as seen through the serial front end
// Notes: addresses are the device register addresses
`ifndef CEF_DEFINES_SVH
`define CEF_DEFINES_SVH
// ****************************************
// register addresses
// ****************************************
`define CEF_ADDR_EFLAGS 8'h2D
`define CEF_ADDR_IRQ_EN 8'h2B
`define CEF_ADDR_IRQ_FLAG 8'h2C
`define CEF_RESET_VAL 8'h00
// ****************************************
// error_state_flags bit positions
// ****************************************
`define CEF_BIT_RX1OVR 7
`define CEF_BIT_RX0OVR 6
`define CEF_BIT_BUSOFF 5
`define CEF_BIT_TX_PASSIVE_FLAG 4
`define CEF_BIT_RX_PASSIVE_FLAG 3
`define CEF_BIT_TX_WARNING_FLAG 2
`define CEF_BIT_RX_WARNING_FLAG 1
`define CEF_BIT_ANY_WARNING_FLAG 0
`define CEF_OVR_MASK 8'hC0
// ****************************************
// irq flag bit positions
// ****************************************
`define CEF_IRQ_RX0 0
`define CEF_IRQ_RX1 1
`define CEF_IRQ_ERR 5
// ****************************************
// counter thresholds
// ****************************************
`define CEF_WARN_LIMIT 8'h60
`define CEF_PASSIVE_LIMIT 8'h80
`define CEF_BUSOFF_LIMIT 8'hFF
`define CEF_NUM_SRC 8
`endif

/* File: cef_pkg.sv */
// Purpose: shared types for the error flag and interrupt core
// Assumes: cef_defines.svh sits in the include path
// Notes: none
package cef_pkg;
    // ****************************************
    // register access from the command front end
    // ****************************************
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] mask;
        logic [7:0] data;
    } cef_reg_req_t;
    // ****************************************
    // per-source interrupt events
    // ****************************************
    typedef struct packed {
        logic [7:0] set;
        logic [7:0] hold;
    } cef_irq_evt_t;
endpackage

/* File: cef_irq_bit.sv */
// Purpose: one interrupt flag with host write and clear hold-off; enable gating is in cef_core
// Assumes: events are single-cycle pulses on clk_i
// Notes: hardware set wins over host clear
`timescale 1ns/1ps
module cef_irq_bit (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // event side
    input wire logic set_i,
    input wire logic hold_i,
    // host side
    input wire logic wr_i,
    input wire logic wdata_i,
    // state
    output logic flag_o
);
    logic flag_q;
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (wr_i) begin
            // clear refused while the cause persists
            flag_d = wdata_i | (flag_q & hold_i);
        end
        if (set_i) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
endmodule

/* File: cef_core.sv */
// Purpose: error state flags and interrupt generation of a CAN controller
// Assumes: counters and events come from logic on clk_i
// Notes: the register port is the byte command port of the serial front end
// Operation
// - buffer one overflow sets when accepted while buffer one still full
// - buffer zero overflow sets likewise and stays until host clears
// - bus-off flag sets when transmit error count reaches 255
// - bus-off clears only after completed recovery sequence
// - transmit passive flag follows transmit count above 127
// - receive passive flag follows receive count at least 128
// - transmit warning flag follows transmit count at least 96
// - receive warning flag follows receive count at least 96
// - combined warning is OR of both warnings
// - eight interrupt sources, each with enable and flag bit
// - enable bit per source gates flag onto interrupt output
// - each event recorded in its flag bit
// - interrupt output low while any enabled flag is set
// - host clear ignored while setting condition persists
// - host may set flags; enabled ones raise interrupt
// - error interrupt on overflow or error state change
`timescale 1ns/1ps
`include "cef_defines.svh"
module cef_core
    import cef_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // register command port
    input wire cef_reg_req_t req_i,
    output logic [7:0] rdata_o,
    // error counters and bus state
    input wire logic [7:0] tx_error_count_i,
    input wire logic [7:0] rx_error_count_i,
    input wire logic recovery_done_i,
    // receive side
    input wire logic rx_accept_buf0_i,
    input wire logic rx_accept_buf1_i,
    // other interrupt sources
    input wire cef_irq_evt_t irq_evt_i,
    // host interrupt
    output logic irq_n_o,
    output logic [7:0] irq_flag_reg_o
);
    // ****************************************
    // state
    // ****************************************
    logic [7:0] irq_enable_reg_q;
    logic rx_buf1_overflow_q;
    logic rx_buf0_overflow_q;
    logic bus_off_flag_q;
    logic tx_passive_flag_q;
    logic rx_passive_flag_q;
    logic tx_warning_flag_q;
    logic rx_warning_flag_q;
    logic [7:0] error_state_flags;
    logic [7:0] err_state_prev_q;
    logic [7:0] irq_flags;
    logic [7:0] src_set;
    logic [7:0] src_hold;
    logic [7:0] masked_wdata;
    logic wr_en;
    logic wr_flag;
    logic wr_error_state_flags;
    logic err_change;
    logic [7:0] rdata_q;

    // masked_bit_write: plain write uses an all-ones mask
    assign masked_wdata = req_i.data & req_i.mask;
    assign wr_en = req_i.wr & (req_i.addr == `CEF_ADDR_IRQ_EN);
    assign wr_flag = req_i.wr & (req_i.addr == `CEF_ADDR_IRQ_FLAG);
    assign wr_error_state_flags = req_i.wr & (req_i.addr == `CEF_ADDR_EFLAGS);

    // ****************************************
    // enable register
    // ****************************************
    // masked write keeps bits outside the mask as they were
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_enable_reg_q <= `CEF_RESET_VAL;
        end else if (wr_en) begin
            irq_enable_reg_q <= masked_wdata
                | (irq_enable_reg_q & ~req_i.mask);
        end
    end

    // ****************************************
    // overflow flags
    // ****************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_buf1_overflow_q <= 1'b0;
            rx_buf0_overflow_q <= 1'b0;
        end else begin
            // only a host write clears; a new overflow wins
            if (rx_accept_buf1_i && irq_flags[`CEF_IRQ_RX1]) begin
                rx_buf1_overflow_q <= 1'b1;
            end else if (wr_error_state_flags && req_i.mask[`CEF_BIT_RX1OVR]) begin
                rx_buf1_overflow_q <= req_i.data[`CEF_BIT_RX1OVR]
                    & rx_buf1_overflow_q;
            end
            if (rx_accept_buf0_i && irq_flags[`CEF_IRQ_RX0]) begin
                rx_buf0_overflow_q <= 1'b1;
            end else if (wr_error_state_flags && req_i.mask[`CEF_BIT_RX0OVR]) begin
                rx_buf0_overflow_q <= req_i.data[`CEF_BIT_RX0OVR]
                    & rx_buf0_overflow_q;
            end
        end
    end

    // ****************************************
    // counter-derived flags
    // ****************************************
    // counter saturates at the limit, so equality marks the reaching point
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_off_flag_q <= 1'b0;
        end else if (tx_error_count_i == `CEF_BUSOFF_LIMIT) begin
            bus_off_flag_q <= 1'b1;
        end else if (recovery_done_i) begin
            bus_off_flag_q <= 1'b0;
        end
    end

    // registered so the readback and change detect see one edge
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_passive_flag_q <= 1'b0;
            rx_passive_flag_q <= 1'b0;
            tx_warning_flag_q <= 1'b0;
            rx_warning_flag_q <= 1'b0;
        end else begin
            tx_passive_flag_q <=
                tx_error_count_i >= `CEF_PASSIVE_LIMIT;
            rx_passive_flag_q <=
                rx_error_count_i >= `CEF_PASSIVE_LIMIT;
            tx_warning_flag_q <=
                tx_error_count_i >= `CEF_WARN_LIMIT;
            rx_warning_flag_q <=
                rx_error_count_i >= `CEF_WARN_LIMIT;
        end
    end

    always_comb begin
        error_state_flags = `CEF_RESET_VAL;
        error_state_flags[`CEF_BIT_RX1OVR] = rx_buf1_overflow_q;
        error_state_flags[`CEF_BIT_RX0OVR] = rx_buf0_overflow_q;
        error_state_flags[`CEF_BIT_BUSOFF] = bus_off_flag_q;
        error_state_flags[`CEF_BIT_TX_PASSIVE_FLAG] = tx_passive_flag_q;
        error_state_flags[`CEF_BIT_RX_PASSIVE_FLAG] = rx_passive_flag_q;
        error_state_flags[`CEF_BIT_TX_WARNING_FLAG] = tx_warning_flag_q;
        error_state_flags[`CEF_BIT_RX_WARNING_FLAG] = rx_warning_flag_q;
        error_state_flags[`CEF_BIT_ANY_WARNING_FLAG] =
            tx_warning_flag_q | rx_warning_flag_q;
    end

    // ****************************************
    // error interrupt source
    // ****************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            err_state_prev_q <= `CEF_RESET_VAL;
        end else begin
            err_state_prev_q <= error_state_flags;
        end
    end

    // rising overflow or any change of the counter-derived state
    assign err_change =
        |(error_state_flags & ~err_state_prev_q & `CEF_OVR_MASK)
        | |((error_state_flags ^ err_state_prev_q)
            & ~`CEF_OVR_MASK);

    always_comb begin
        src_set = irq_evt_i.set;
        src_hold = irq_evt_i.hold;
        src_set[`CEF_IRQ_ERR] = irq_evt_i.set[`CEF_IRQ_ERR] | err_change;
    end

    // ****************************************
    // interrupt flags, one per source
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < `CEF_NUM_SRC; gi = gi + 1) begin : g_src
            cef_irq_bit u_bit (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .set_i(src_set[gi]),
                .hold_i(src_hold[gi]),
                .wr_i(wr_flag & req_i.mask[gi]),
                .wdata_i(req_i.data[gi]),
                .flag_o(irq_flags[gi])
            );
        end
    endgenerate

    // combinational so the pin follows the flag in the same cycle
    assign irq_n_o = ~|(irq_flags & irq_enable_reg_q);
    assign irq_flag_reg_o = irq_flags;

    // ****************************************
    // read data
    // ****************************************
    // unmapped addresses read as zero rather than aliasing a register
    // one cycle of latency keeps the read path off the combinational decode
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= `CEF_RESET_VAL;
        end else begin
            case (req_i.addr)
                `CEF_ADDR_EFLAGS: rdata_q <= error_state_flags;
                `CEF_ADDR_IRQ_EN: rdata_q <= irq_enable_reg_q;
                `CEF_ADDR_IRQ_FLAG: rdata_q <= irq_flags;
                default: rdata_q <= `CEF_RESET_VAL;
            endcase
        end
    end
    assign rdata_o = rdata_q;
endmodule

/* File: cef_core_monitor.sv */
// Purpose: port checker for cef_core
// Assumes: one clock, async active-low reset
// Notes: error flags are seen only through the registered read port
`timescale 1ns/1ps
module cef_core_mon
    import cef_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire cef_reg_req_t req_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] tx_error_count_i,
    input wire logic [7:0] rx_error_count_i,
    input wire logic recovery_done_i,
    input wire cef_irq_evt_t irq_evt_i,
    input wire logic irq_n_o,
    input wire logic [7:0] irq_flag_reg_o
);
    // ********
    // helpers
    // ********
    // read checks wait for three cycles of history after reset
    logic [1:0] age_q;
    logic rd_q;
    logic chk;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) age_q <= 2'h0;
        else if (age_q != 2'h3) age_q <= age_q + 2'h1;
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) rd_q <= 1'b0;
        else rd_q <= req_i.addr == 8'h2D;
    end
    assign chk = rd_q && age_q == 2'h3;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_tx_warn_read: assert property (
        chk |-> rdata_o[2] == ($past(tx_error_count_i, 2) >= 8'h60))
        else $error("tx warning bit wrong");
    a_rx_warn_read: assert property (
        chk |-> rdata_o[1] == ($past(rx_error_count_i, 2) >= 8'h60))
        else $error("rx warning bit wrong");
    a_any_warn_or: assert property (
        chk |-> rdata_o[0] == (rdata_o[1] | rdata_o[2]))
        else $error("combined warning bit wrong");
    a_tx_pass_read: assert property (
        chk |-> rdata_o[4] == ($past(tx_error_count_i, 2) >= 8'h80))
        else $error("tx passive bit wrong");
    a_rx_pass_read: assert property (
        chk |-> rdata_o[3] == ($past(rx_error_count_i, 2) >= 8'h80))
        else $error("rx passive bit wrong");
    a_bus_off_set: assert property (
        chk && $past(tx_error_count_i, 2) == 8'hFF |-> rdata_o[5])
        else $error("bus-off bit not set");
    a_bus_off_hold: assert property (
        chk && $past(chk) && $fell(rdata_o[5]) |-> $past(recovery_done_i, 2))
        else $error("bus-off cleared without recovery");
    a_irq_idle_high: assert property (
        irq_flag_reg_o == 8'h00 |-> irq_n_o)
        else $error("interrupt low with no flag");
    a_clear_held_off: assert property (
        ($past(irq_flag_reg_o) & $past(irq_evt_i.hold) & ~irq_flag_reg_o)
            == 8'h00)
        else $error("held flag was cleared");
    cover property (!irq_n_o);
    cover property (chk && rdata_o[5]);
    cover property (chk && rdata_o[7]);
endmodule
bind cef_core cef_core_mon i_cef_core_mon (.*);

/* File: cef_host.sv */
// Purpose: host model issuing register commands
// Assumes: commands launch on the falling edge
// Notes: flag clears always use masked writes
`timescale 1ns/1ps
module cef_host
    import cef_pkg::*;
(
    // clock
    input wire logic clk_i,
    // register port
    output cef_reg_req_t req_o,
    input wire logic [7:0] rdata_i
);
    initial req_o = '0;
    // mask limits the write so live flags are not overwritten
    task automatic wr(input logic [7:0] a, m, d);
        @(negedge clk_i);
        req_o <= {1'b1, a, m, d};
        @(negedge clk_i);
        req_o.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge clk_i);
        req_o <= {1'b0, a, 8'h00, 8'h00};
        @(negedge clk_i);
        q = rdata_i;
    endtask
endmodule

/* File: can_error_flags_and_irq_bench.sv */
// Purpose: self-checking bench for cef_core
// Assumes: inputs change on the falling edge
// Notes: expected flags come from a small model of the counters
`timescale 1ns/1ps
module can_error_flags_and_irq_bench;
    import cef_pkg::*;
    logic clk_i, reset_n_i, rec, acc0, acc1, irq_n, bo;
    logic [7:0] tx, rx, rdata, iflag, q, en, fm;
    logic [1:0] ovr;
    logic [31:0] seed;
    logic [7:0] ra [4] = '{8'h2D, 8'h2B, 8'h2C, 8'h3F};
    logic [7:0] bnd [6] = '{8'h5F, 8'h60, 8'h7F, 8'h80, 8'hFE, 8'hFF};
    cef_reg_req_t req;
    cef_irq_evt_t evt;
    int err_total, cmp_count, cyc;
    cef_core i_cef_core (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req),
        .rdata_o(rdata), .tx_error_count_i(tx), .rx_error_count_i(rx),
        .recovery_done_i(rec), .rx_accept_buf0_i(acc0),
        .rx_accept_buf1_i(acc1), .irq_evt_i(evt), .irq_n_o(irq_n),
        .irq_flag_reg_o(iflag));
    cef_host i_cef_host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));
    // ********
    // helpers
    // ********
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] ef();
        ef = {ovr, bo, tx >= 8'h80, rx >= 8'h80, tx >= 8'h60, rx >= 8'h60,
            tx >= 8'h60 || rx >= 8'h60};
    endfunction
    task automatic chk(input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, exp);
        i_cef_host.rd(a, q);
        chk(q, exp);
    endtask
    task automatic st_chk();
        chk(iflag, fm);
        chk({7'h00, irq_n}, {7'h00, ~|(fm & en)});
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // a hang past this ceiling counts as a mismatch
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        {reset_n_i, rec, acc0, acc1, bo} = 5'h00;
        {tx, rx, en, fm} = 32'h0;
        {ovr, evt} = '0;
        seed = 32'hCAF7A989;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i) reset_n_i = 1'b1;
        foreach (ra[i]) rd_chk(ra[i], 8'h00);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            tx = (i < 6) ? bnd[i] : seed[7:0];
            rx = (i < 6) ? bnd[5 - i] : seed[15:8];
            if (tx == 8'hFF) bo = 1'b1;
            rd_chk(8'h2D, ef());
        end
        tx = 8'hFF;
        bo = 1'b1;
        i_cef_host.wr(8'h2D, 8'hFF, 8'h00);
        tx = 8'h10;
        rd_chk(8'h2D, ef());
        @(negedge clk_i) rec = 1'b1;
        @(negedge clk_i) rec = 1'b0;
        bo = 1'b0;
        rd_chk(8'h2D, ef());
        for (int b = 0; b < 2; b++) begin
            // accept while the buffer is empty must not count as overflow
            i_cef_host.wr(8'h2C, 8'h20, 8'h00);
            {acc1, acc0} = b ? 2'h2 : 2'h1;
            @(negedge clk_i) {acc1, acc0} = 2'h0;
            rd_chk(8'h2D, ef());
            chk({7'h00, iflag[5]}, 8'h00);
            @(negedge clk_i) evt.set[b] = 1'b1;
            @(negedge clk_i) evt.set[b] = 1'b0;
            {acc1, acc0} = b ? 2'h2 : 2'h1;
            @(negedge clk_i) {acc1, acc0} = 2'h0;
            ovr[b] = 1'b1;
            rd_chk(8'h2D, ef());
            chk({7'h00, iflag[5]}, 8'h01);
            i_cef_host.wr(8'h2D, 8'hFF, 8'hFF);
            rd_chk(8'h2D, ef());
            i_cef_host.wr(8'h2D, b ? 8'h80 : 8'h40, 8'h00);
            ovr[b] = 1'b0;
            rd_chk(8'h2D, ef());
        end
        i_cef_host.wr(8'h2C, 8'hFF, 8'h00);
        st_chk();
        for (int i = 0; i < 8; i++) begin
            en = 8'h01 << i;
            i_cef_host.wr(8'h2B, 8'hFF, en);
            rd_chk(8'h2B, en);
            @(negedge clk_i) evt.set[i] = 1'b1;
            evt.hold[i] = 1'b1;
            @(negedge clk_i) evt.set[i] = 1'b0;
            fm = en;
            st_chk();
            i_cef_host.wr(8'h2C, en, 8'h00);
            st_chk();
            evt.hold[i] = 1'b0;
            i_cef_host.wr(8'h2C, en, 8'h00);
            fm = 8'h00;
            st_chk();
            i_cef_host.wr(8'h2C, en, 8'hFF);
            fm = en;
            st_chk();
            rd_chk(8'h2C, fm);
            en = ~en;
            i_cef_host.wr(8'h2B, 8'hFF, en);
            st_chk();
            i_cef_host.wr(8'h2C, 8'hFF, 8'h00);
            fm = 8'h00;
        end
        close_out();
    end
endmodule
